/* File: hdl/dtt_ctrl.sv */
// Trigger selection, transfer control and APB register window of the acquisition card
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
module dtt_ctrl
  import dtt_pkg::*;
#(
  parameter int ADDR_WIDTH = 8,
  parameter int DIO_WIDTH  = 16
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  ce,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_WIDTH-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  trigger_source_jumper,
  input  wire logic                  external_trigger_input,
  input  wire logic                  pacer_output,
  input  wire logic                  irq_level_enable,
  output logic                       adc_start,
  input  wire logic                  adc_done,
  input  wire logic [11:0]           adc_data,
  output logic      [11:0]           conv_result,
  output logic                       irq_request,
  output logic                       dma_request,
  input  wire logic                  dma_ack,
  output logic      [1:0]            timer_port_sel,
  output logic      [7:0]            timer_wdata,
  output logic                       timer_write,
  output logic                       timer_read,
  input  wire logic [7:0]            timer_rdata,
  input  wire logic [DIO_WIDTH-1:0]  digital_inputs,
  output logic      [DIO_WIDTH-1:0]  digital_outputs,
  output logic      [11:0]           dac1_code,
  output logic      [11:0]           dac2_code
);

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  localparam int HALF = DIO_WIDTH / 2;

  logic [3:0]      reg_idx;
  logic            upper_zero;
  logic            map_ok;
  logic            apb_access;
  logic            xfer_done;
  logic            wr_done;
  logic            rd_done;
  logic [7:0]      wbyte;
  logic [7:0]      rbyte;
  logic [2:0]      op_mode_reg;
  logic            not_ready_reg;
  logic            irq_flag_reg;
  logic            ext_prev_reg;
  logic            pacer_prev_reg;
  dtt_conv_state_t conv_state_reg;
  logic            ext_rise;
  logic            pacer_rise;
  logic            soft_fire;
  logic            trig_fire;
  logic            conv_end;

  assign reg_idx    = paddr[5:2];
  assign upper_zero = (paddr[1:0] == 2'h0) && ((paddr >> 6) == '0);
  assign apb_access = psel && penable && !pready;
  assign xfer_done  = psel && penable && pready;
  assign wr_done    = xfer_done && pwrite && map_ok;
  assign rd_done    = xfer_done && !pwrite && map_ok;
  assign wbyte      = pwdata[7:0];

  always_comb begin
    map_ok = upper_zero;
    unique case (reg_idx)
      IDX_TIMER_COUNTER0, IDX_TIMER_COUNTER1, IDX_TIMER_COUNTER2, IDX_TIMER_CONTROL,
      IDX_DAC1_LOW, IDX_DAC1_HIGH, IDX_DAC2_LOW_DIN_LOW, IDX_DAC2_HIGH_DIN_HI,
      IDX_IRQ_FLAG_CLEAR, IDX_OPERATION_MODE, IDX_SOFT_TRIGGER,
      IDX_DIGITAL_OUT_LOW, IDX_DIGITAL_OUT_HIGH: map_ok = upper_zero;
      default:                                   map_ok = 1'b0;
    endcase
  end

  // Write-only locations read as zero
  always_comb begin
    rbyte = 8'h00;
    unique case (reg_idx)
      IDX_TIMER_COUNTER0, IDX_TIMER_COUNTER1,
      IDX_TIMER_COUNTER2, IDX_TIMER_CONTROL: rbyte = timer_rdata;
      IDX_DAC1_LOW:                          rbyte = conv_result[7:0];
      IDX_DAC1_HIGH:                         rbyte = {3'h0, not_ready_reg, conv_result[11:8]};
      IDX_DAC2_LOW_DIN_LOW:                  rbyte = digital_inputs[HALF-1:0];
      IDX_DAC2_HIGH_DIN_HI:                  rbyte = digital_inputs[DIO_WIDTH-1:HALF];
      default:                               rbyte = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // APB answer: one wait state, data and error sampled in the access cycle
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else if (ce) begin
      pready <= apb_access;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce && apb_access) begin
      prdata  <= (map_ok && !pwrite) ? {24'h00_0000, rbyte} : 32'h0000_0000;
      pslverr <= !map_ok;
    end
  end

  // ----------------------------------------------------------------
  // Timer port window
  // ----------------------------------------------------------------
  // Port select follows the setup phase so the timer has a full cycle to answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_port_sel <= 2'h0;
    end else if (ce && psel && !penable && (reg_idx < 4'(TIMER_PORTS))) begin
      timer_port_sel <= reg_idx[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_write <= 1'b0;
      timer_read  <= 1'b0;
      timer_wdata <= 8'h00;
    end else if (ce) begin
      timer_write <= wr_done && (reg_idx < 4'(TIMER_PORTS));
      timer_read  <= rd_done && (reg_idx < 4'(TIMER_PORTS));
      if (wr_done && (reg_idx < 4'(TIMER_PORTS))) begin
        timer_wdata <= wbyte;
      end
    end
  end

  // ----------------------------------------------------------------
  // Operation mode and digital outputs
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_mode_reg <= RST_OP_MODE;
    end else if (ce && wr_done && (reg_idx == IDX_OPERATION_MODE)) begin
      op_mode_reg <= wbyte[OP_SEL_LSB +: OP_SEL_WIDTH];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      digital_outputs <= RST_DIGITAL_OUT;
    end else if (ce && wr_done) begin
      if (reg_idx == IDX_DIGITAL_OUT_LOW) begin
        digital_outputs[HALF-1:0] <= wbyte;
      end
      if (reg_idx == IDX_DIGITAL_OUT_HIGH) begin
        digital_outputs[DIO_WIDTH-1:HALF] <= wbyte;
      end
    end
  end

  // ----------------------------------------------------------------
  // DAC channels
  // ----------------------------------------------------------------
  dtt_dac_chan u_dac1 (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .low_we  (wr_done && (reg_idx == IDX_DAC1_LOW)),
    .high_we (wr_done && (reg_idx == IDX_DAC1_HIGH)),
    .wdata   (wbyte),
    .code    (dac1_code)
  );

  dtt_dac_chan u_dac2 (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .low_we  (wr_done && (reg_idx == IDX_DAC2_LOW_DIN_LOW)),
    .high_we (wr_done && (reg_idx == IDX_DAC2_HIGH_DIN_HI)),
    .wdata   (wbyte),
    .code    (dac2_code)
  );

  // ----------------------------------------------------------------
  // Trigger selection
  // ----------------------------------------------------------------
  // Trigger inputs are synchronous, so a single history flop suffices for edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_prev_reg   <= 1'b0;
      pacer_prev_reg <= 1'b0;
    end else if (ce) begin
      ext_prev_reg   <= external_trigger_input;
      pacer_prev_reg <= pacer_output;
    end
  end

  assign ext_rise   = external_trigger_input && !ext_prev_reg;
  assign pacer_rise = pacer_output && !pacer_prev_reg;
  assign soft_fire  = wr_done && (reg_idx == IDX_SOFT_TRIGGER) && (op_mode_reg == OP_SOFT_POLL);

  always_comb begin
    if (trigger_source_jumper) begin
      trig_fire = ext_rise;
    end else begin
      unique case (op_mode_reg)
        OP_SOFT_POLL:               trig_fire = soft_fire;
        OP_PACER_DMA, OP_PACER_IRQ: trig_fire = pacer_rise;
        default:                    trig_fire = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Conversion sequencing
  // ----------------------------------------------------------------
  assign conv_end = (conv_state_reg == CONV_BUSY) && adc_done;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_state_reg <= CONV_IDLE;
      adc_start      <= 1'b0;
    end else if (ce) begin
      adc_start <= trig_fire && (conv_state_reg == CONV_IDLE);
      unique case (conv_state_reg)
        CONV_IDLE: begin
          if (trig_fire) begin
            conv_state_reg <= CONV_BUSY;
          end
        end
        CONV_BUSY: begin
          if (adc_done) begin
            conv_state_reg <= CONV_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_result <= RST_RESULT;
    end else if (ce && conv_end) begin
      conv_result <= adc_data;
    end
  end

  // Completion beats a simultaneous low-byte read so fresh data is never hidden
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      not_ready_reg <= RST_NOT_READY;
    end else if (ce) begin
      if (conv_end) begin
        not_ready_reg <= 1'b0;
      end else if (trig_fire && (conv_state_reg == CONV_IDLE)) begin
        not_ready_reg <= 1'b1;
      end else if (rd_done && (reg_idx == IDX_DAC1_LOW)) begin
        not_ready_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transfer requests
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_flag_reg <= 1'b0;
    end else if (ce) begin
      if (conv_end && (op_mode_reg == OP_PACER_IRQ)) begin
        irq_flag_reg <= 1'b1;
      end else if (wr_done && (reg_idx == IDX_IRQ_FLAG_CLEAR)) begin
        irq_flag_reg <= 1'b0;
      end
    end
  end

  // A held flag means one request line level, so no second edge until cleared or until irq_level_enable drops and returns
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_request <= 1'b0;
    end else if (ce) begin
      irq_request <= irq_flag_reg && irq_level_enable;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_request <= 1'b0;
    end else if (ce) begin
      if (conv_end && (op_mode_reg == OP_PACER_DMA)) begin
        dma_request <= 1'b1;
      end else if (dma_ack) begin
        dma_request <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence seq_setup;
    psel && !penable && ce;
  endsequence

  sequence seq_access;
    psel && penable && ce;
  endsequence

  sequence seq_soft_write;
    ce && wr_done && (reg_idx == IDX_SOFT_TRIGGER);
  endsequence

  chk_mode_decode: assert property (ce && trig_fire && !trigger_source_jumper
      |-> (op_mode_reg == OP_SOFT_POLL) || (op_mode_reg == OP_PACER_DMA) || (op_mode_reg == OP_PACER_IRQ))
    else $error("trigger fired in a mode without an internal source");

  chk_apb_wait: assert property (seq_setup ##1 seq_access |-> !pready ##1 (pready || !ce))
    else $error("APB answer not given after one wait state");

  chk_soft_start: assert property (seq_soft_write and (op_mode_reg == OP_SOFT_POLL && !trigger_source_jumper
      && conv_state_reg == CONV_IDLE) |=> adc_start ##1 (!adc_start || !$past(ce)))
    else $error("software trigger did not give one start pulse");

  chk_ext_only: assert property (ce && trigger_source_jumper && !ext_rise |=> !adc_start)
    else $error("internal source started a conversion in external mode");

  chk_ext_start: assert property (ce && trigger_source_jumper && ext_rise && conv_state_reg == CONV_IDLE
      |=> adc_start && not_ready_reg)
    else $error("external rising edge did not start a conversion");

  chk_busy_ignore: assert property (ce && conv_state_reg == CONV_BUSY |=> !adc_start)
    else $error("trigger accepted during a conversion");

  chk_done_ready: assert property (ce && conv_end |=> !not_ready_reg && conv_result == $past(adc_data))
    else $error("result or ready flag wrong after conversion end");

  chk_read_notready: assert property (ce && rd_done && reg_idx == IDX_DAC1_LOW && !conv_end
      |=> not_ready_reg)
    else $error("low byte read did not restore the not-ready flag");

  chk_irq_raise: assert property (ce && conv_end && op_mode_reg == OP_PACER_IRQ && irq_level_enable
      ##1 ce && irq_level_enable |=> irq_request)
    else $error("no interrupt after conversion in interrupt mode");

  chk_irq_hold: assert property (irq_flag_reg && !(ce && wr_done && reg_idx == IDX_IRQ_FLAG_CLEAR)
      |=> irq_flag_reg)
    else $error("interrupt flag dropped without a clear write");

  chk_dma_req: assert property (ce && conv_end && op_mode_reg == OP_PACER_DMA |=> dma_request)
    else $error("no DMA request after conversion in DMA mode");

  chk_dac_stage: assert property (ce && wr_done && reg_idx == IDX_DAC1_LOW |=> $stable(dac1_code))
    else $error("DAC output moved on a low byte write");

  chk_dout_write: assert property (ce && wr_done && reg_idx == IDX_DIGITAL_OUT_HIGH
      |=> digital_outputs[DIO_WIDTH-1:HALF] == $past(pwdata[7:0]))
    else $error("digital output high byte not written");

endmodule : dtt_ctrl

/* File: hdl/dtt_dac_chan.sv */
// One double-buffered DAC channel: staged low byte, code updated on the high byte write
`timescale 1ns/1ps
module dtt_dac_chan
  import dtt_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        low_we,
  input  wire logic        high_we,
  input  wire logic [7:0]  wdata,
  output logic      [11:0] code
);

  logic [7:0] stage_reg;

  // ----------------------------------------------------------------
  // Staging and one-step update
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_reg <= RST_DAC_STAGE;
    end else if (ce && low_we) begin
      stage_reg <= wdata;
    end
  end

  // Upper nibble of the high byte is dropped on purpose
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code <= RST_DAC_CODE;
    end else if (ce && high_we) begin
      code <= {wdata[DAC_HIGH_WIDTH-1:0], stage_reg};
    end
  end

endmodule : dtt_dac_chan

/* File: hdl/dtt_pkg.sv */
// Package with register map, field layout, modes and reset values of the trigger and transfer control block
package dtt_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_TIMER_COUNTER0   = 4'h0;
  localparam logic [3:0] IDX_TIMER_COUNTER1   = 4'h1;
  localparam logic [3:0] IDX_TIMER_COUNTER2   = 4'h2;
  localparam logic [3:0] IDX_TIMER_CONTROL    = 4'h3;
  localparam logic [3:0] IDX_DAC1_LOW         = 4'h4;
  localparam logic [3:0] IDX_DAC1_HIGH        = 4'h5;
  localparam logic [3:0] IDX_DAC2_LOW_DIN_LOW = 4'h6;
  localparam logic [3:0] IDX_DAC2_HIGH_DIN_HI = 4'h7;
  localparam logic [3:0] IDX_IRQ_FLAG_CLEAR   = 4'h8;
  localparam logic [3:0] IDX_OPERATION_MODE   = 4'hB;
  localparam logic [3:0] IDX_SOFT_TRIGGER     = 4'hC;
  localparam logic [3:0] IDX_DIGITAL_OUT_LOW  = 4'hD;
  localparam logic [3:0] IDX_DIGITAL_OUT_HIGH = 4'hE;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int OP_SEL_LSB      = 0;
  localparam int OP_SEL_WIDTH    = 3;
  localparam int RESULT_NRDY_BIT = 4;
  localparam int DAC_HIGH_WIDTH  = 4;
  localparam int TIMER_PORTS     = 4;

  // ----------------------------------------------------------------
  // Operation field codes
  // ----------------------------------------------------------------
  localparam logic [2:0] OP_INTERNAL_OFF = 3'h0;
  localparam logic [2:0] OP_SOFT_POLL    = 3'h1;
  localparam logic [2:0] OP_PACER_DMA    = 3'h2;
  localparam logic [2:0] OP_PACER_IRQ    = 3'h6;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0]  RST_OP_MODE     = OP_SOFT_POLL;
  localparam logic [11:0] RST_DAC_CODE    = 12'h000;
  localparam logic [7:0]  RST_DAC_STAGE   = 8'h00;
  localparam logic [15:0] RST_DIGITAL_OUT = 16'h0000;
  localparam logic [11:0] RST_RESULT      = 12'h000;
  localparam logic        RST_NOT_READY   = 1'b1;

  typedef enum logic {
    CONV_IDLE,
    CONV_BUSY
  } dtt_conv_state_t;

endpackage : dtt_pkg

/* File: verif/dtt_conv_model.sv */
// Converter model answering each start pulse with a done pulse and a numbered result
`timescale 1ns/1ps
module dtt_conv_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       adc_start,
  output logic            adc_done,
  output logic     [11:0] adc_data,
  output logic     [7:0]  n_starts
);
  logic [3:0] cnt_reg;
  // Eight cycles of conversion, long enough for a second host write to land while busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg  <= 4'h0;
      n_starts <= 8'h00;
      adc_done <= 1'b0;
    end else begin
      adc_done <= (cnt_reg == 4'h1);
      if (adc_start) begin
        cnt_reg  <= 4'h8;
        n_starts <= n_starts + 8'h01;
      end else if (cnt_reg != 4'h0) begin
        cnt_reg <= cnt_reg - 4'h1;
      end
    end
  end
  // Outside the done pulse the data lines carry the inverse, so a stale capture shows
  assign adc_data = adc_done ? {4'hB, n_starts} : ~{4'hB, n_starts};
endmodule : dtt_conv_model

/* File: verif/tb.sv */
// Testbench for the trigger and transfer control block
`timescale 1ns/1ps
module tb;
  import dtt_pkg::*;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr, n_starts, exp_starts;
  logic [31:0] pwdata, prdata, rd;
  logic        jumper, ext_in, pacer, irq_en, adc_start, adc_done, irq_request, dma_request, dma_ack;
  logic [11:0] adc_data, conv_result, dac1_code, dac2_code;
  logic [1:0]  timer_port_sel;
  logic [7:0]  timer_wdata, timer_rdata;
  logic        timer_write, timer_read;
  logic [15:0] din, dout;
  logic [9:0]  tw_log;
  logic [7:0]  tr_cnt;
  logic [2:0]  codes [5];
  int          err_total, n_compared, cyc;

  dtt_ctrl u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trigger_source_jumper(jumper), .external_trigger_input(ext_in), .pacer_output(pacer),
    .irq_level_enable(irq_en), .adc_start(adc_start), .adc_done(adc_done), .adc_data(adc_data),
    .conv_result(conv_result), .irq_request(irq_request), .dma_request(dma_request), .dma_ack(dma_ack),
    .timer_port_sel(timer_port_sel), .timer_wdata(timer_wdata), .timer_write(timer_write),
    .timer_read(timer_read), .timer_rdata(timer_rdata), .digital_inputs(din), .digital_outputs(dout),
    .dac1_code(dac1_code), .dac2_code(dac2_code));
  dtt_conv_model u_conv (.pclk(pclk), .presetn(presetn), .adc_start(adc_start), .adc_done(adc_done),
    .adc_data(adc_data), .n_starts(n_starts));

  // Timer read data follows the selected port combinationally
  assign timer_rdata = {6'h28, timer_port_sel};
  always @(posedge pclk) begin
    cyc++;
    if (timer_write === 1'b1) tw_log <= {timer_port_sel, timer_wdata};
    if (timer_read === 1'b1) tr_cnt <= tr_cnt + 8'h01;
    if (cyc == 5000) begin
      err_total++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [3:0] idx, input logic [7:0] wd);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    // Only the cycle ceiling ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic pulse(input logic ext);
    if (ext) ext_in <= 1'b1;
    else pacer <= 1'b1;
    repeat (3) @(posedge pclk);
    ext_in <= 1'b0;
    pacer  <= 1'b0;
    @(posedge pclk);
  endtask : pulse

  // Polls the flag, then reads the result and sees the flag rearm
  task automatic conv_check;
    int i;
    i = 0;
    do begin
      apb(1'b0, 4'h5, 8'h00);
      i++;
    end while (rd[4] !== 1'b0 && i < 20);
    chk("result high", {28'h0, 4'hB}, rd);
    apb(1'b0, 4'h4, 8'h00);
    chk("result low", {24'h0, n_starts}, rd);
    apb(1'b0, 4'h5, 8'h00);
    chk("flag rearmed", 32'h1B, rd);
  endtask : conv_check

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, jumper, ext_in, pacer, irq_en, dma_ack} = '0;
    {paddr, pwdata, din, tw_log, exp_starts, tr_cnt} = '0;
    ce = 1'b1;
    codes = '{3'h0, 3'h3, 3'h4, 3'h5, 3'h7};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 4'h5, 8'h00);
    chk("flag at reset", 32'h10, rd);
    chk("dout at reset", 32'h0, {16'h0, dout});
    apb(1'b1, 4'hC, 8'hA5);
    apb(1'b1, 4'hC, 8'h5A);
    chk("starts busy", 32'h1, {24'h0, n_starts});
    conv_check();
    din <= 16'hA55A;
    apb(1'b0, 4'h6, 8'h00);
    chk("din low", 32'h5A, rd);
    apb(1'b0, 4'h7, 8'h00);
    chk("din high", 32'hA5, rd);
    apb(1'b1, 4'hD, 8'h3C);
    apb(1'b1, 4'hE, 8'hC3);
    chk("dout", 32'hC33C, {16'h0, dout});
    apb(1'b1, 4'h4, 8'h34);
    chk("dac1 staged", 32'h0, {20'h0, dac1_code});
    apb(1'b1, 4'h5, 8'hF2);
    chk("dac1", 32'h234, {20'h0, dac1_code});
    apb(1'b1, 4'h6, 8'hCD);
    apb(1'b1, 4'h7, 8'h1A);
    chk("dac2", 32'hACD, {20'h0, dac2_code});
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, 4'(k), 8'h70 + 8'(k));
      // Strobe lands one cycle after completion, so let the log settle
      @(posedge pclk);
      chk("timer write", {22'h0, 2'(k), 8'h70 + 8'(k)}, {22'h0, tw_log});
      apb(1'b0, 4'(k), 8'h00);
      chk("timer read", {24'h0, 6'h28, 2'(k)}, rd);
    end
    @(posedge pclk);
    chk("timer read strobes", 32'h4, {24'h0, tr_cnt});
    apb(1'b1, 4'h9, 8'hFF);
    chk("unmapped err", 32'h1, {31'h0, er});
    apb(1'b0, 4'hB, 8'h00);
    chk("write-only read", 32'h0, rd);
    exp_starts = n_starts;
    foreach (codes[c]) begin
      apb(1'b1, 4'hB, {5'h00, codes[c]});
      apb(1'b1, 4'hC, 8'h00);
      pulse(1'b0);
      chk("no internal start", {24'h0, exp_starts}, {24'h0, n_starts});
    end
    apb(1'b1, 4'hB, 8'h06);
    pulse(1'b0);
    conv_check();
    chk("irq masked", 32'h0, {31'h0, irq_request});
    irq_en <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("irq raised", 32'h1, {31'h0, irq_request});
    apb(1'b1, 4'h8, 8'h00);
    repeat (2) @(posedge pclk);
    chk("irq cleared", 32'h0, {31'h0, irq_request});
    pulse(1'b0);
    conv_check();
    chk("irq again", 32'h1, {31'h0, irq_request});
    apb(1'b1, 4'h8, 8'h00);
    apb(1'b1, 4'hB, 8'h02);
    pulse(1'b0);
    conv_check();
    chk("dma request", 32'h1, {31'h0, dma_request});
    dma_ack <= 1'b1;
    @(posedge pclk);
    dma_ack <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("dma acked", 32'h0, {31'h0, dma_request});
    jumper <= 1'b1;
    exp_starts = n_starts;
    pulse(1'b0);
    apb(1'b1, 4'hB, 8'h01);
    apb(1'b1, 4'hC, 8'h00);
    chk("internal ignored", {24'h0, exp_starts}, {24'h0, n_starts});
    apb(1'b1, 4'hB, 8'h02);
    pulse(1'b1);
    conv_check();
    chk("ext dma", 32'h1, {31'h0, dma_request});
    chk("ext start", {24'h0, exp_starts + 8'h01}, {24'h0, n_starts});
    // An edge that comes and goes while the enable is low must leave no trace
    ce <= 1'b0;
    exp_starts = n_starts;
    pulse(1'b1);
    ce <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("frozen start", {24'h0, exp_starts}, {24'h0, n_starts});
    close_out();
  end
endmodule : tb
